// file: verilog/scsalu_core.sv
// Sign-count and subtract datapath slice with its register port
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`include "scsalu_defines.svh"

module scsalu_core (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire scsalu_pkg::scsalu_bus_t bus,
	output logic [31:0]                rdata,
	output logic                       zero_flag,
	output logic                       negative_flag,
	output logic                       carry_flag,
	output logic                       out_of_range,
	output logic                       sticky_out_of_range,
	output logic                       op_done
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Redundant sign bits below the sign bit of a width-bit value
	function automatic logic [5:0] scsalu_redundant(
		input logic [39:0] v,
		input logic [5:0]  width
	);
		logic       done;
		logic       sgn;
		logic [5:0] n;
		done = 1'b0;
		n    = 6'h00;
		sgn  = v[width - 6'h01];
		for (int i = 38; i >= 0; i--) begin
			if ((i < int'(width) - 1) && !done) begin
				if (v[i] == sgn) begin
					n = n + 6'h01;
				end else begin
					done = 1'b1;
				end
			end
		end
		return n;
	endfunction

	// Left-justified subtract: 16-bit operands sit in bits 31..16,
	// so carry, overflow and clamp values serve both widths
	function automatic scsalu_pkg::scsalu_diff_t scsalu_sub(
		input logic [31:0] a,
		input logic [31:0] b,
		input logic        sat
	);
		scsalu_pkg::scsalu_diff_t d;
		logic [32:0]              sum;
		sum     = {1'b0, a} + {1'b0, ~b} + 33'h0_0000_0001;
		d.carry = sum[32];
		d.ovf   = (a[31] != b[31]) && (sum[31] != a[31]);
		if (sat && d.ovf) begin
			d.result = a[31] ? `SCSALU_SAT_MIN : `SCSALU_SAT_MAX;
		end else begin
			d.result = sum[31:0];
		end
		return d;
	endfunction

	function automatic logic [15:0] scsalu_half(
		input logic [31:0] w,
		input logic        hi
	);
		return hi ? w[31:16] : w[15:0];
	endfunction

	// ****************************************************************
	// Register map decode
	// ****************************************************************

	// Word-aligned offsets up to the last data register
	function automatic logic scsalu_is_dreg(
		input logic [7:0] addr
	);
		return (addr <= `SCSALU_OFF_DREG7)
			&& (addr[1:0] == 2'h0);
	endfunction

	// Data register number from a byte offset
	function automatic logic [2:0] scsalu_dreg_idx(
		input logic [7:0] addr
	);
		return addr[4:2];
	endfunction

	// Low word or zero-extended extension byte of an accumulator
	function automatic logic [31:0] scsalu_acc_read(
		input logic [39:0] acc,
		input logic        ext
	);
		return ext ? {24'h00_0000, acc[39:32]} : acc[31:0];
	endfunction

	// Only the low byte of a write reaches the extension bits
	function automatic logic [39:0] scsalu_acc_write(
		input logic [39:0] acc,
		input logic [31:0] wdata,
		input logic        ext
	);
		return ext ? {wdata[7:0], acc[31:0]} : {acc[39:32], wdata};
	endfunction

	// Replace one half of a word, keeping the other
	function automatic logic [31:0] scsalu_put_half(
		input logic [31:0] w,
		input logic [15:0] h,
		input logic        hi
	);
		return hi ? {h, w[15:0]} : {w[31:16], h};
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	scsalu_pkg::scsalu_state_t state;
	scsalu_pkg::scsalu_state_t next_state;
	scsalu_pkg::scsalu_cmd_t   cmd;
	scsalu_pkg::scsalu_diff_t  diff;
	logic [31:0]               op_a;
	logic [31:0]               op_b;
	logic                      sat_eff;
	logic [5:0]                cnt;
	logic signed [6:0]         acc_cnt;
	logic [15:0]               sign_res;
	logic [39:0]               acc_sel;
	logic                      wr_hit;

	assign cmd = scsalu_pkg::scsalu_cmd_t'(bus.wdata);

	// ****************************************************************
	// Operand selection and arithmetic
	// ****************************************************************
	always_comb begin
		acc_sel = cmd.src1[0] ? state.accumulator_one
			: state.accumulator_zero;
		cnt      = 6'h00;
		acc_cnt  = 7'sh00;
		sign_res = 16'h0000;
		case (cmd.size)
			`SCSALU_SIZE_16: begin
				cnt = scsalu_redundant({24'h00_0000,
					scsalu_half(state.dreg[cmd.src1], cmd.src1_hi)},
					`SCSALU_W16);
				sign_res = {10'h000, cnt};
			end
			`SCSALU_SIZE_32: begin
				cnt = scsalu_redundant({8'h00, state.dreg[cmd.src1]},
					`SCSALU_W32);
				sign_res = {10'h000, cnt};
			end
			`SCSALU_SIZE_40: begin
				cnt = scsalu_redundant(acc_sel, `SCSALU_W40);
				// Extension growth leaves fewer than eight redundant
				// bits, so the count goes negative and a shift by it
				// moves the value down into 32 bits
				acc_cnt  = $signed({1'b0, cnt}) - `SCSALU_ACC_GUARD;
				sign_res = {{9{acc_cnt[6]}}, acc_cnt};
			end
			default: begin
				cnt      = 6'h00;
				sign_res = 16'h0000;
			end
		endcase
	end

	always_comb begin
		if (cmd.size == `SCSALU_SIZE_32) begin
			op_a    = state.dreg[cmd.src1];
			op_b    = state.dreg[cmd.src2];
			sat_eff = cmd.long_form && cmd.sat;
		end else begin
			// Sizes 16 and 40 both take the 16-bit half path
			op_a    = {scsalu_half(state.dreg[cmd.src1], cmd.src1_hi),
				16'h0000};
			op_b    = {scsalu_half(state.dreg[cmd.src2], cmd.src2_hi),
				16'h0000};
			sat_eff = cmd.sat;
		end
		diff = scsalu_sub(op_a, op_b, sat_eff);
	end

	// ****************************************************************
	// Next-state logic: register port and command execution
	// ****************************************************************
	always_comb begin
		next_state         = state;
		next_state.rdata   = `SCSALU_RST_WORD;
		next_state.op_done = 1'b0;
		wr_hit             = bus.wr;

		// Register reads: data stands for one cycle only
		// Zero when idle, so a missed strobe never shows stale data
		if (bus.rd) begin
			if (scsalu_is_dreg(bus.addr)) begin
				next_state.rdata = state.dreg[scsalu_dreg_idx(bus.addr)];
			end else begin
				case (bus.addr)
					`SCSALU_OFF_ACC0_LO:
						next_state.rdata =
							scsalu_acc_read(state.accumulator_zero, 1'b0);
					`SCSALU_OFF_ACC0_EXT:
						next_state.rdata =
							scsalu_acc_read(state.accumulator_zero, 1'b1);
					`SCSALU_OFF_ACC1_LO:
						next_state.rdata =
							scsalu_acc_read(state.accumulator_one, 1'b0);
					`SCSALU_OFF_ACC1_EXT:
						next_state.rdata =
							scsalu_acc_read(state.accumulator_one, 1'b1);
					`SCSALU_OFF_STATUS:
						next_state.rdata = {state.spare, state.flags};
					`SCSALU_OFF_CMD:
						next_state.rdata = state.last_cmd;
					default:
						next_state.rdata = `SCSALU_RST_WORD;
				endcase
			end
		end

		// Register writes; unmapped addresses are ignored
		if (wr_hit) begin
			if (scsalu_is_dreg(bus.addr)) begin
				next_state.dreg[scsalu_dreg_idx(bus.addr)] = bus.wdata;
			end else begin
				case (bus.addr)
					`SCSALU_OFF_ACC0_LO:
						next_state.accumulator_zero = scsalu_acc_write(
							state.accumulator_zero, bus.wdata, 1'b0);
					`SCSALU_OFF_ACC0_EXT:
						next_state.accumulator_zero = scsalu_acc_write(
							state.accumulator_zero, bus.wdata, 1'b1);
					`SCSALU_OFF_ACC1_LO:
						next_state.accumulator_one = scsalu_acc_write(
							state.accumulator_one, bus.wdata, 1'b0);
					`SCSALU_OFF_ACC1_EXT:
						next_state.accumulator_one = scsalu_acc_write(
							state.accumulator_one, bus.wdata, 1'b1);
					`SCSALU_OFF_STATUS: begin
						next_state.spare = bus.wdata[31:5];
						next_state.flags = bus.wdata[4:0];
					end
					`SCSALU_OFF_CMD: begin
						next_state.last_cmd = bus.wdata;
						// The operation runs on the write edge itself;
						// no status write can share this cycle, so a
						// sticky set never races a software clear
						case (cmd.op)
							`SCSALU_OP_SIGN: begin
								// Only the low half of the destination
								// changes; flags are left alone
								next_state.dreg[cmd.dest] =
									scsalu_put_half(state.dreg[cmd.dest],
									sign_res, 1'b0);
								next_state.op_done = 1'b1;
							end
							`SCSALU_OP_SUB: begin
								if (cmd.size == `SCSALU_SIZE_32) begin
									next_state.dreg[cmd.dest] = diff.result;
								end else begin
									next_state.dreg[cmd.dest] =
										scsalu_put_half(state.dreg[cmd.dest],
										diff.result[31:16],
										cmd.dest_hi);
								end
								// Low bits are zero for 16-bit work unless clamped to the
								// maximum, so the 32-bit tests hold for both sizes
								next_state.flags.zero_flag =
									(diff.result == `SCSALU_RST_WORD);
								next_state.flags.negative_flag =
									diff.result[31];
								next_state.flags.carry_flag = diff.carry;
								next_state.flags.out_of_range = diff.ovf;
								next_state.flags.sticky_out_of_range =
									state.flags.sticky_out_of_range
									| diff.ovf;
								// Spare status bits are not touched here
								next_state.spare = state.spare;
								next_state.op_done = 1'b1;
							end
							default: begin
								next_state.op_done = 1'b0;
							end
						endcase
					end
					default: begin
						next_state.op_done = 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk) begin
		// Every field cleared, so nothing starts out unknown
		if (srst) begin
			state.dreg             <= '0;
			state.accumulator_zero <= `SCSALU_RST_ACC;
			state.accumulator_one  <= `SCSALU_RST_ACC;
			state.spare            <= '0;
			state.flags            <= '0;
			state.last_cmd         <= `SCSALU_RST_WORD;
			state.rdata            <= `SCSALU_RST_WORD;
			state.op_done          <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Outputs, all straight from the state register
	// ****************************************************************
	assign rdata               = state.rdata;
	assign zero_flag           = state.flags.zero_flag;
	assign negative_flag       = state.flags.negative_flag;
	assign carry_flag          = state.flags.carry_flag;
	assign out_of_range        = state.flags.out_of_range;
	assign sticky_out_of_range = state.flags.sticky_out_of_range;
	assign op_done             = state.op_done;

endmodule

// file: verilog/scsalu_defines.svh
// Address map, command codes and constants of the sign-count/subtract ALU
`ifndef SCSALU_DEFINES_SVH
`define SCSALU_DEFINES_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define SCSALU_ADDR_W       8
`define SCSALU_DATA_W       32

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCSALU_OFF_DREG0    8'h00
`define SCSALU_OFF_DREG7    8'h1C
`define SCSALU_OFF_ACC0_LO  8'h20
`define SCSALU_OFF_ACC0_EXT 8'h24
`define SCSALU_OFF_ACC1_LO  8'h28
`define SCSALU_OFF_ACC1_EXT 8'h2C
`define SCSALU_OFF_STATUS   8'h30
`define SCSALU_OFF_CMD      8'h34

// ****************************************************************
// Command codes
// ****************************************************************
`define SCSALU_OP_NONE      2'h0
`define SCSALU_OP_SIGN      2'h1
`define SCSALU_OP_SUB       2'h2
`define SCSALU_SIZE_16      2'h0
`define SCSALU_SIZE_32      2'h1
`define SCSALU_SIZE_40      2'h2

// ****************************************************************
// Widths, limits and reset values
// ****************************************************************
`define SCSALU_W16          6'h10
`define SCSALU_W32          6'h20
`define SCSALU_W40          6'h28
`define SCSALU_ACC_GUARD    7'sh08
`define SCSALU_SAT_MAX      32'h7FFF_FFFF
`define SCSALU_SAT_MIN      32'h8000_0000
`define SCSALU_RST_WORD     32'h0000_0000
`define SCSALU_RST_ACC      40'h00_0000_0000

`endif

// file: verilog/scsalu_pkg.sv
// Types shared by the sign-count/subtract ALU and its bench
package scsalu_pkg;

	// ****************************************************************
	// Register bus request
	// ****************************************************************
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} scsalu_bus_t;

	// ****************************************************************
	// Command word, written to the command register
	// ****************************************************************
	typedef struct packed {
		logic [13:0] unused;
		logic        dest_hi;
		logic [2:0]  dest;
		logic        src2_hi;
		logic [2:0]  src2;
		logic        src1_hi;
		logic [2:0]  src1;
		logic [1:0]  size;
		logic        sat;
		logic        long_form;
		logic [1:0]  op;
	} scsalu_cmd_t;

	// ****************************************************************
	// Arithmetic status flags, status register bits 4..0
	// ****************************************************************
	typedef struct packed {
		logic sticky_out_of_range;
		logic out_of_range;
		logic carry_flag;
		logic negative_flag;
		logic zero_flag;
	} scsalu_flags_t;

	typedef struct packed {
		logic [31:0] result;
		logic        carry;
		logic        ovf;
	} scsalu_diff_t;

	// ****************************************************************
	// Complete state of the block
	// ****************************************************************
	typedef struct packed {
		logic [7:0][31:0] dreg;
		logic [39:0]      accumulator_zero;
		logic [39:0]      accumulator_one;
		logic [26:0]      spare;
		scsalu_flags_t    flags;
		logic [31:0]      last_cmd;
		logic [31:0]      rdata;
		logic             op_done;
	} scsalu_state_t;

endpackage

// file: sim/scsalu_chk_sva.sv
// Port checker of the sign-count/subtract ALU
`include "scsalu_defines.svh"

module scsalu_chk (
	input wire logic                    clk,
	input wire logic                    srst,
	input wire scsalu_pkg::scsalu_bus_t bus,
	input wire logic [31:0]             rdata,
	input wire logic                    zero_flag,
	input wire logic                    negative_flag,
	input wire logic                    carry_flag,
	input wire logic                    out_of_range,
	input wire logic                    sticky_out_of_range,
	input wire logic                    op_done
);
	// ********
	// Decoded strobes
	// ********
	logic       cmd_w;
	logic       sub_w;
	logic       sign_w;
	logic       op_w;
	logic       stat_w;
	logic       stk_src;
	logic [4:0] fl;
	assign cmd_w   = bus.wr && bus.addr == `SCSALU_OFF_CMD;
	assign sub_w   = cmd_w && bus.wdata[1:0] == `SCSALU_OP_SUB;
	assign sign_w  = cmd_w && bus.wdata[1:0] == `SCSALU_OP_SIGN;
	assign op_w    = sub_w || sign_w;
	assign stat_w  = bus.wr && bus.addr == `SCSALU_OFF_STATUS;
	// Status writes may legally set the sticky bit too
	assign stk_src = sub_w || stat_w;
	assign fl      = {sticky_out_of_range, out_of_range, carry_flag,
		negative_flag, zero_flag};
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ********
	// Assertions
	// ********
	done_after_op_a:
		assert property (op_w |=> op_done)
		else $error("no done pulse after a command");
	done_only_op_a:
		assert property (!op_w |=> !op_done)
		else $error("done pulse without a command");
	sign_keeps_flags_a:
		assert property (sign_w |=> $stable(fl))
		else $error("sign count changed a flag");
	idle_keeps_flags_a:
		assert property (!sub_w && !stat_w |=> $stable(fl))
		else $error("flags changed without a subtract");
	zero_not_neg_a:
		assert property (sub_w |=> !(zero_flag && negative_flag))
		else $error("zero and negative both set");
	ovf_nonzero_a:
		assert property (sub_w |=> !(out_of_range && zero_flag))
		else $error("overflow with a zero result");
	sticky_follow_a:
		assert property (sub_w |=> !out_of_range || sticky_out_of_range)
		else $error("sticky flag missed an overflow");
	sticky_rise_a:
		assert property ($rose(sticky_out_of_range) |-> $past(stk_src))
		else $error("sticky flag rose without cause");
	sticky_keep_a:
		assert property (sticky_out_of_range && !stat_w |=> sticky_out_of_range)
		else $error("sticky flag dropped");
	read_idle_a:
		assert property (!bus.rd |=> rdata == `SCSALU_RST_WORD)
		else $error("read data outside its cycle");
	cover property (sub_w ##1 out_of_range);
	cover property (sign_w ##1 op_done);
	cover property (stat_w ##1 !sticky_out_of_range);
endmodule

bind scsalu_core scsalu_chk chk_i (.clk(clk), .srst(srst), .bus(bus),
	.rdata(rdata), .zero_flag(zero_flag), .negative_flag(negative_flag),
	.carry_flag(carry_flag), .out_of_range(out_of_range),
	.sticky_out_of_range(sticky_out_of_range), .op_done(op_done));

// file: sim/sign_count_and_subtract_alu_tb.sv
// Self-checking bench of the sign-count/subtract ALU
module sign_count_and_subtract_alu_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ********
	// Signals
	// ********
	typedef struct packed {
		logic [1:0]  sz;
		logic        l;
		logic        s;
		logic        h;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] r;
		logic [4:0]  f;
	} scsalu_case_t;
	logic                    clk = 1'b0;
	logic                    srst = 1'b1;
	scsalu_pkg::scsalu_bus_t bus = '0;
	logic [31:0]             rdata;
	logic                    zero_flag;
	logic                    negative_flag;
	logic                    carry_flag;
	logic                    out_of_range;
	logic                    sticky_out_of_range;
	logic                    op_done;
	logic [4:0]              flags;
	int                      n_errors = 0;
	int                      n_checks = 0;
	int                      w;
	scsalu_case_t            c;
	logic [41:0]             t;
	logic [31:0]             x;
	logic [41:0]             sg [13] = '{
		{2'h1,40'h00_0000_0000}, {2'h1,40'h00_FFFF_FFFF},
		{2'h1,40'h00_0000_0001}, {2'h1,40'h00_8000_0000},
		{2'h0,40'h00_0000_0000}, {2'h0,40'h00_0000_FFFF},
		{2'h0,40'h00_0000_C000}, {2'h0,40'h00_0000_7FFF},
		{2'h2,40'h00_0000_0000}, {2'h2,40'hFF_FFFF_FFFF},
		{2'h2,40'h01_0000_0000}, {2'h2,40'h7F_FFFF_FFFF},
		{2'h2,40'hFF_8000_0000}};
	// Order matters: sticky set by the first case, kept by the rest
	scsalu_case_t            sc [8] = '{
		{2'h1,3'h2,32'h8000_0000,32'h0000_0001,32'h7FFF_FFFF,5'h1C},
		{2'h1,3'h6,32'h8000_0000,32'h0000_0001,32'h8000_0000,5'h1E},
		{2'h1,3'h4,32'h0000_0005,32'h0000_0005,32'h0000_0000,5'h15},
		{2'h1,3'h4,32'h0000_0003,32'h0000_0005,32'hFFFF_FFFE,5'h12},
		{2'h1,3'h6,32'h7FFF_FFFF,32'hFFFF_FFFF,32'h7FFF_FFFF,5'h18},
		{2'h0,3'h7,32'h0000_8000,32'h0000_7FFF,32'h0000_8000,5'h1E},
		{2'h0,3'h4,32'h0000_0005,32'h0000_0001,32'h0000_0004,5'h14},
		{2'h0,3'h1,32'h0000_8000,32'h0000_0001,32'h0000_7FFF,5'h1C}};
	assign flags = {sticky_out_of_range, out_of_range, carry_flag,
		negative_flag, zero_flag};
	always #12.5 clk = ~clk;
	scsalu_core dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
		.zero_flag(zero_flag), .negative_flag(negative_flag),
		.carry_flag(carry_flag), .out_of_range(out_of_range),
		.sticky_out_of_range(sticky_out_of_range), .op_done(op_done));
	// ********
	// Tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	// One strobe cycle, then idle; result sampled after the answer edge
	task automatic cyc(input logic [7:0] a, input logic [31:0] d,
		input logic wr);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: wr, rd: !wr};
		@(posedge clk);
		bus <= '0;
		#1;
	endtask
	task automatic bwr(input logic [7:0] a, input logic [31:0] d);
		cyc(a, d, 1'b1);
	endtask
	task automatic brd(input logic [7:0] a, input logic [31:0] exp);
		cyc(a, 32'h0000_0000, 1'b0);
		chk(rdata, exp);
		// Read data stands for one cycle only, then returns to zero
		@(posedge clk);
		#1;
		chk(rdata, 32'h0000_0000);
	endtask
	function automatic logic [31:0] cmd(input logic [1:0] op, sz,
		input logic l, s, input logic [2:0] s1, input logic s1h, s2h,
		input logic [2:0] d, input logic dh);
		scsalu_pkg::scsalu_cmd_t k;
		k = '0;
		k.op = op;
		k.long_form = l;
		k.sat = s;
		k.size = sz;
		k.src1 = s1;
		k.src1_hi = s1h;
		k.src2 = 3'h2;
		k.src2_hi = s2h;
		k.dest = d;
		k.dest_hi = dh;
		return k;
	endfunction
	function automatic logic [15:0] cnt(input logic [39:0] v, input int n0);
		int n;
		n = 0;
		while (n < n0 - 1 && v[n0 - 2 - n] == v[n0 - 1])
			n++;
		return 16'(n0 == 40 ? n - 8 : n);
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		#1_000_000;
		n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		brd(8'h30, 32'h0000_0000);
		brd(8'h38, 32'h0000_0000);
		brd(8'h02, 32'h0000_0000);
		bwr(8'h30, 32'h0000_0015);
		foreach (sg[i]) begin
			t = sg[i];
			w = t[41:40] == 2'h0 ? 16 : t[41:40] == 2'h1 ? 32 : 40;
			x = t[41:40] == 2'h0 ? {t[15:0], ~t[15:0]} : t[31:0];
			bwr(8'h00, 32'hA5A5_0000);
			bwr(8'h04, x);
			bwr(8'h28, t[31:0]);
			bwr(8'h2C, {24'h00_0000, t[39:32]});
			bwr(8'h34, cmd(2'h1, t[41:40], 1'b0, 1'b0, 3'h1, w == 16,
				1'b0, 3'h0, 1'b0));
			chk(32'(op_done), 32'h0000_0001);
			chk(32'(flags), 32'h0000_0015);
			brd(8'h00, {16'hA5A5, cnt(t[39:0], w)});
			brd(8'h04, x);
			brd(8'h2C, {24'h00_0000, t[39:32]});
		end
		// First accumulator, ext write keeps only its low byte
		bwr(8'h20, 32'h0000_00FF);
		bwr(8'h24, 32'hFFFF_FF80);
		bwr(8'h34, cmd(2'h1, 2'h2, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 3'h3,
			1'b0));
		brd(8'h0C, 32'h0000_FFF8);
		brd(8'h20, 32'h0000_00FF);
		brd(8'h24, 32'h0000_0080);
		brd(8'h28, 32'h8000_0000);
		bwr(8'h04, 32'h0000_0003);
		bwr(8'h34, cmd(2'h1, 2'h1, 1'b0, 1'b0, 3'h1, 1'b0, 1'b0, 3'h1, 1'b0));
		brd(8'h04, 32'h0000_001D);
		bwr(8'h30, 32'hFFFF_FFE0);
		chk(32'(flags), 32'h0000_0000);
		brd(8'h30, 32'hFFFF_FFE0);
		foreach (sc[i]) begin
			c = sc[i];
			bwr(8'h00, 32'h5A5A_ABCD);
			bwr(8'h04, c.sz[0] ? c.a : {c.a[15:0], ~c.a[15:0]});
			x = c.h ? {c.b[15:0], ~c.b[15:0]} : {~c.b[15:0], c.b[15:0]};
			bwr(8'h08, c.sz[0] ? c.b : x);
			bwr(8'h34, cmd(2'h2, c.sz, c.l, c.s, 3'h1, !c.sz[0], c.h,
				3'h0, c.h));
			chk(32'(flags), 32'(c.f));
			x = c.h ? {c.r[15:0], 16'hABCD} : {16'h5A5A, c.r[15:0]};
			brd(8'h00, c.sz[0] ? c.r : x);
		end
		// An unused op code must leave results and flags alone
		x = cmd(2'h3, 2'h1, 1'b1, 1'b1, 3'h1, 1'b0, 1'b0, 3'h0, 1'b0);
		bwr(8'h34, x);
		chk(32'(op_done), 32'h0000_0000);
		chk(32'(flags), 32'h0000_001C);
		brd(8'h34, x);
		brd(8'h00, 32'h7FFF_ABCD);
		bwr(8'h3C, 32'hFFFF_FFFF);
		brd(8'h3C, 32'h0000_0000);
		// Reset in mid-run clears registers, status and outputs
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		brd(8'h00, 32'h0000_0000);
		brd(8'h24, 32'h0000_0000);
		brd(8'h30, 32'h0000_0000);
		brd(8'h34, 32'h0000_0000);
		chk(32'(flags), 32'h0000_0000);
		tally_and_finish;
	end
endmodule
